//--- bench/module_power_state_sequencer_tb.sv
// module_power_state_sequencer_tb: bench for the power-state sequencer
`timescale 1ns/100ps
`default_nettype none

module module_power_state_sequencer_tb;
  logic       clk_i   = 1'b0;
  logic       rst_n_i = 1'b1;
  logic       want_on = 1'b0;
  logic       pull    = 1'b0;
  logic       strap   = 1'b0;
  logic [2:0] dly     = 3'h0;
  logic       s_good  = 1'b0;
  logic       therm   = 1'b0;
  logic       uv      = 1'b0;
  logic       sw_sd   = 1'b0;
  logic       sw_run  = 1'b0;
  logic       slp     = 1'b0;
  logic       vb_en   = 1'b0;
  logic [7:0] wk      = 8'h00;
  logic [1:0] csel    = 2'h0;
  logic [3:0] cw_en   = 4'h0;
  logic       p_en, pull_n, strap_n, cb_sup;
  logic       rl_oe_n, sd_oe_n, asl_n, sup_en, soc_n, sto_n, recov, hold;
  logic       rl_o, sd_o;
  logic [1:0] ps;
  // both lines have pull-ups: a driven line shows the driven level
  wire        rst_line = (rl_oe_n | rl_o) & pull_n;
  wire        sd_line  = sd_oe_n | sd_o;
  int         n_fail     = 0;
  int         n_compared = 0;
  int         seed       = 32'hbfd4;
  int         cycles     = 0;
  int         i;

  psq_sequencer dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .power_en_i(p_en),
    .module_reset_line_i(rst_line), .module_reset_line_o(rl_o),
    .module_reset_line_oe_n_o(rl_oe_n), .shutdown_req_i(sd_line),
    .shutdown_req_o(sd_o), .shutdown_req_oe_n_o(sd_oe_n),
    .recovery_strap_n_i(strap_n), .asleep_indicator_n_o(asl_n),
    .supply_good_i(s_good), .thermal_trip_i(therm), .undervolt_i(uv),
    .temp_hot_i(wk[0]), .temp_cold_i(wk[1]), .vbus_i(wk[2]),
    .conn_wake_i(wk[3] ? 4'h1 << csel : 4'h0), .spi_wake_i(wk[4]),
    .i2c_wake_i(wk[5]), .rtc_wake_i(wk[6]), .usb_wake_i(wk[7]),
    .sw_shutdown_i(sw_sd), .sw_running_i(sw_run), .sleep_req_i(slp),
    .vbus_wake_en_i(vb_en), .conn_wake_en_i(cw_en),
    .supply_enable_o(sup_en), .soc_reset_n_o(soc_n),
    .storage_reset_n_o(sto_n), .recovery_mode_o(recov),
    .io_hold_o(hold), .power_state_o(ps));

  psq_carrier_model cb (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .want_on_i(want_on),
    .pull_i(pull), .strap_sel_i(strap), .dly_i(dly),
    .rst_line_i(rst_line), .shdn_line_i(sd_line), .power_en_o(p_en),
    .pull_oe_n_o(pull_n), .strap_n_o(strap_n), .supply_on_o(cb_sup));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic go(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // sample well after the edge so register updates have landed
  task automatic look(input int n);
    go(n);
    #10;
  endtask

  task automatic chk(input string nm, input logic seen,
                     input logic exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chk_st(input int e);
    chk("state_hi", ps[1], e[1]);
    chk("state_lo", ps[0], e[0]);
    chk("asleep_n", asl_n, e != 2);
  endtask

  task automatic power_up(input logic rec);
    go(1);
    strap <= rec;
    want_on <= 1'b1;
    look(20);
    chk("supply_en", sup_en, 1'b1);
    chk("rst_oe_n", rl_oe_n, 1'b0);
    chk("cb_supply", cb_sup, 1'b0);
    chk_st(1);
    go(1);
    s_good <= 1'b1;
    look(8);
    chk("rst_oe_n", rl_oe_n, 1'b1);
    chk("soc_n", soc_n, 1'b1);
    chk("storage_n", sto_n, 1'b1);
    chk("recovery", recov, rec);
    chk("cb_supply", cb_sup, 1'b1);
  endtask

  task automatic off_seq();
    go(1);
    s_good <= 1'b0;
    want_on <= 1'b0;
    therm <= 1'b0;
    uv <= 1'b0;
    sw_sd <= 1'b0;
    sw_run <= 1'b0;
    look(6);
    chk_st(0);
    chk("shdn_oe_n", sd_oe_n, 1'b1);
    chk("rst_oe_n", rl_oe_n, 1'b0);
    chk("cb_supply", cb_sup, 1'b0);
  endtask

  task automatic shut(input int c);
    go(1);
    dly <= 3'($random(seed));
    sw_sd <= 1'b1;
    look(6);
    chk("shdn_oe_n", sd_oe_n, 1'b1);
    go(1);
    sw_run <= (c == 0);
    therm <= (c == 1);
    uv <= (c == 2);
    look(6);
    chk("shdn_oe_n", sd_oe_n, 1'b0);
    chk("rst_oe_n", rl_oe_n, 1'b1);
    chk("supply_en", sup_en, 1'b1);
    look(50);
    chk("rst_oe_n", rl_oe_n, 1'b0);
    chk("supply_en", sup_en, 1'b0);
    off_seq();
  endtask

  task automatic sleep();
    go(1);
    slp <= 1'b1;
    go(1);
    slp <= 1'b0;
    look(2);
    chk_st(2);
    chk("io_hold", hold, 1'b1);
    chk("rst_oe_n", rl_oe_n, 1'b1);
    chk("supply_en", sup_en, 1'b1);
  endtask

  initial begin
    #1 rst_n_i = 1'b0;
    go(6);
    rst_n_i <= 1'b1;
    look(2);
    chk_st(0);
    chk("rst_oe_n", rl_oe_n, 1'b0);
    chk("shdn_oe_n", sd_oe_n, 1'b1);
    chk("soc_n", soc_n, 1'b0);
    go(1);
    slp <= 1'b1;
    therm <= 1'b1;
    look(5);
    chk_st(0);
    go(1);
    slp <= 1'b0;
    therm <= 1'b0;
    power_up(1'b1);
    // a dip shorter than the shutdown time must be ignored
    go(1);
    want_on <= 1'b0;
    go(20 + ($random(seed) & 63));
    want_on <= 1'b1;
    look(8);
    chk("rst_oe_n", rl_oe_n, 1'b1);
    chk_st(1);
    go(1);
    want_on <= 1'b0;
    look(90);
    chk("shdn_oe_n", sd_oe_n, 1'b1);
    look(20);
    chk("shdn_oe_n", sd_oe_n, 1'b0);
    chk("rst_oe_n", rl_oe_n, 1'b0);
    chk("supply_en", sup_en, 1'b0);
    off_seq();
    power_up(1'b0);
    for (i = 0; i < 8; i++) begin
      sleep();
      if (i == 2) begin
        go(1);
        wk <= 8'h0C;
        look(6);
        chk_st(2);
        go(1);
        wk <= 8'h00;
        go(4);
        vb_en <= 1'b1;
        cw_en <= 4'hF;
      end
      go(1);
      csel <= 2'($random(seed));
      wk <= 8'h01 << i;
      look(5);
      chk_st(1);
      chk("io_hold", hold, 1'b0);
      go(1);
      wk <= 8'h00;
      go(4);
    end
    go(1);
    pull <= 1'b1;
    strap <= 1'b1;
    look(5);
    chk("soc_n", soc_n, 1'b0);
    chk("storage_n", sto_n, 1'b0);
    chk_st(1);
    go(1);
    pull <= 1'b0;
    look(5);
    chk("soc_n", soc_n, 1'b1);
    chk("recovery", recov, 1'b1);
    shut(0);
    power_up(1'b0);
    sleep();
    shut(1);
    power_up(1'b0);
    shut(2);
    final_report();
  end
endmodule  // module_power_state_sequencer_tb

`default_nettype wire

//--- bench/psq_carrier_model.sv
// psq_carrier_model: carrier-board side of the power handshake
`timescale 1ns/100ps
`default_nettype none

module psq_carrier_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // commands from the bench
  input  wire logic       want_on_i,
  input  wire logic       pull_i,
  input  wire logic       strap_sel_i,
  input  wire logic [2:0] dly_i,
  // wired connector lines
  input  wire logic       rst_line_i,
  input  wire logic       shdn_line_i,
  // carrier outputs
  output logic            power_en_o,
  output logic            pull_oe_n_o,
  output logic            strap_n_o,
  output logic            supply_on_o
);
  logic [3:0] vdd_q;
  logic [5:0] wait_q;
  logic       drop_q;

  assign pull_oe_n_o = ~pull_i;
  assign strap_n_o   = ~strap_sel_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vdd_q       <= 4'h0;
      wait_q      <= 6'h00;
      drop_q      <= 1'b0;
      power_en_o  <= 1'b0;
      supply_on_o <= 1'b0;
    end else begin
      if (vdd_q != 4'hF) begin
        vdd_q <= vdd_q + 4'h1;
      end
      if (!want_on_i) begin
        wait_q <= 6'h00;
        drop_q <= 1'b0;
      end else if (!shdn_line_i && !drop_q) begin
        // slow carrier: never answers before eight cycles
        wait_q <= wait_q + 6'h01;
        drop_q <= (wait_q == {1'b0, dly_i, 2'h0} + 6'h08);
      end
      // main supply must settle before the request goes up
      power_en_o  <= want_on_i & (vdd_q == 4'hF) & ~drop_q;
      supply_on_o <= rst_line_i & power_en_o;
    end
  end
endmodule  // psq_carrier_model

`default_nettype wire

//--- verilog/psq_pin_if.sv
// psq_pin_if: raw pin levels into the synchroniser and their synced copies
`timescale 1ns/100ps
`default_nettype none

interface psq_pin_if;
  logic [psq_pkg::SYNC_W-1:0] raw;
  logic [psq_pkg::SYNC_W-1:0] synced;

  modport syncer (input raw, output synced);
  modport core   (output raw, input synced);
endinterface

`default_nettype wire

//--- verilog/psq_pin_sync.sv
// psq_pin_sync: two-flop synchroniser for every asynchronous pin level
`timescale 1ns/100ps
`default_nettype none

module psq_pin_sync (
  // clock and reset
  input  wire logic     clk_i,
  input  wire logic     rst_n_i,
  // pins in, synced levels out
  psq_pin_if.syncer     pins
);

  typedef struct packed {
    logic [psq_pkg::SYNC_W-1:0] meta;
    logic [psq_pkg::SYNC_W-1:0] stable;
  } psq_sync_type;

  psq_sync_type q;
  psq_sync_type d;

  // meta is read only by the second stage
  always_comb begin
    d        = q;
    d.meta   = pins.raw;
    d.stable = q.meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= {(2 * psq_pkg::SYNC_W){psq_pkg::SYNC_RST}};
    end else begin
      q <= d;
    end
  end

  assign pins.synced = q.stable;

endmodule // psq_pin_sync

`default_nettype wire

//--- verilog/psq_pkg.sv
// psq_pkg: shared constants and types for the module power-state sequencer
package psq_pkg;

  // timing: the clock period and the hardware-shutdown low time
  localparam int CLK_PERIOD_NS = 100;
  localparam int HW_OFF_LOW_NS = 10000;
  localparam int CNT_W         = 8;
  // least time, so the cycle count rounds up
  localparam logic [CNT_W-1:0] HW_OFF_CYC =
    CNT_W'((HW_OFF_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // wake source groups
  localparam int NUM_CONN_WAKE   = 4;
  localparam int NUM_PERIPH_WAKE = 4;

  // bit positions inside the synchronised pin vector
  localparam int SB_PWR_EN    = 0;
  localparam int SB_RST_LINE  = 1;
  localparam int SB_STRAP_N   = 2;
  localparam int SB_PWR_GOOD  = 3;
  localparam int SB_THERM     = 4;
  localparam int SB_UVOLT     = 5;
  localparam int SB_TEMP_HOT  = 6;
  localparam int SB_TEMP_COLD = 7;
  localparam int SB_VBUS      = 8;
  localparam int SB_CONN_LO   = 9;
  localparam int SB_PERIPH_LO = SB_CONN_LO + NUM_CONN_WAKE;
  localparam int SB_SHDN_LINE = SB_PERIPH_LO + NUM_PERIPH_WAKE;
  localparam int SYNC_W       = SB_SHDN_LINE + 1;

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_OFF       = 6'h01,
    ST_PWR_UP    = 6'h02,
    ST_ON        = 6'h04,
    ST_SLEEP     = 6'h08,
    ST_SHUT_WAIT = 6'h10,
    ST_PWR_DOWN  = 6'h20
  } psq_state_type;

  // coarse power state reported to the rest of the module
  localparam logic [1:0] PST_OFF   = 2'h0;
  localparam logic [1:0] PST_ON    = 2'h1;
  localparam logic [1:0] PST_SLEEP = 2'h2;

  // reset values of the registered outputs and of the synchroniser flops
  localparam logic RST_LINE_OE_N_RST = 1'h0;
  localparam logic SHDN_OE_N_RST     = 1'h1;
  localparam logic ASLEEP_N_RST      = 1'h1;
  localparam logic PMIC_EN_RST       = 1'h0;
  localparam logic SOC_RST_N_RST     = 1'h0;
  localparam logic RECOVERY_RST      = 1'h0;
  localparam logic IO_HOLD_RST       = 1'h0;
  localparam logic SYNC_RST          = 1'h0;

endpackage

//--- verilog/psq_sequencer.sv
// psq_sequencer: OFF/ON/SLEEP power sequencer facing the carrier board
//
// Notes on behaviour
// - OFF goes to ON only on a rising edge of the power-on request.
// - Module releases reset line after its own power sequence completes.
// - Reset line low holds processor and onboard storage in reset.
// - In ON, power-on request low for 10 us starts hardware shutdown.
// - Any shutdown cause drives the shutdown request output low; undervolt and software shutdown are acted on only in ON.
// - Supply shutdown starts only after the power-on request has dropped.
// - Reset line goes low after request falls; supplies may then go off.
// - OFF is the reset default and is entered only from ON.
// - SLEEP only from ON; ON only from OFF or SLEEP.
// - Software shutdown only while software runs; thermal from power-up, ON or SLEEP.
// - In SLEEP the reset line, shutdown request and supply enable keep their levels from before sleep.
// - SLEEP is left only on a wake event or a thermal trip.
// - Temperature beyond hot or cold limits wakes a sleeping module.
// - VBUS and connector wake signals can be enabled as wake events.
// - Peripheral wake sources (SPI, I2C, clock, USB) leave deep sleep.
// - Asleep indicator is low while in deep sleep.
// - Strap low when reset line rises selects USB recovery mode.
`timescale 1ns/100ps
`default_nettype none

module psq_sequencer (
  // clock and reset
  input  wire logic                                 clk_i,
  input  wire logic                                 rst_n_i,
  // carrier board handshake
  input  wire logic                                 power_en_i,
  input  wire logic                                 module_reset_line_i,
  output logic                                      module_reset_line_o,
  output logic                                      module_reset_line_oe_n_o,
  input  wire logic                                 shutdown_req_i,
  output logic                                      shutdown_req_o,
  output logic                                      shutdown_req_oe_n_o,
  input  wire logic                                 recovery_strap_n_i,
  output logic                                      asleep_indicator_n_o,
  // on-module supply and event inputs
  input  wire logic                                 supply_good_i,
  input  wire logic                                 thermal_trip_i,
  input  wire logic                                 undervolt_i,
  input  wire logic                                 temp_hot_i,
  input  wire logic                                 temp_cold_i,
  // wake sources
  input  wire logic                                 vbus_i,
  input  wire logic [psq_pkg::NUM_CONN_WAKE-1:0]    conn_wake_i,
  input  wire logic                                 spi_wake_i,
  input  wire logic                                 i2c_wake_i,
  input  wire logic                                 rtc_wake_i,
  input  wire logic                                 usb_wake_i,
  // software requests and wake configuration, same clock
  input  wire logic                                 sw_shutdown_i,
  input  wire logic                                 sw_running_i,
  input  wire logic                                 sleep_req_i,
  input  wire logic                                 vbus_wake_en_i,
  input  wire logic [psq_pkg::NUM_CONN_WAKE-1:0]    conn_wake_en_i,
  // on-module controls and status
  output logic                                      supply_enable_o,
  output logic                                      soc_reset_n_o,
  output logic                                      storage_reset_n_o,
  output logic                                      recovery_mode_o,
  output logic                                      io_hold_o,
  output logic [1:0]                                power_state_o
);

  typedef struct packed {
    psq_pkg::psq_state_type       st;
    logic [psq_pkg::CNT_W-1:0]    low_cnt;
    logic                         pe_prev;
    logic                         rl_prev;
    logic                         rst_oe_n;
    logic                         shdn_oe_n;
    logic                         asleep_n;
    logic                         pmic_en;
    logic                         soc_rst_n;
    logic                         recovery;
    logic                         io_hold;
    logic [1:0]                   pstate;
  } psq_core_type;

  localparam psq_core_type CORE_RST = '{
    st:        psq_pkg::ST_OFF,
    low_cnt:   '0,
    pe_prev:   psq_pkg::SYNC_RST,
    rl_prev:   psq_pkg::SYNC_RST,
    rst_oe_n:  psq_pkg::RST_LINE_OE_N_RST,
    shdn_oe_n: psq_pkg::SHDN_OE_N_RST,
    asleep_n:  psq_pkg::ASLEEP_N_RST,
    pmic_en:   psq_pkg::PMIC_EN_RST,
    soc_rst_n: psq_pkg::SOC_RST_N_RST,
    recovery:  psq_pkg::RECOVERY_RST,
    io_hold:   psq_pkg::IO_HOLD_RST,
    pstate:    psq_pkg::PST_OFF
  };

  psq_core_type q;
  psq_core_type d;

  // pin synchronisation
  psq_pin_if pins ();

  assign pins.raw = {shutdown_req_i,
                     usb_wake_i, rtc_wake_i, i2c_wake_i, spi_wake_i,
                     conn_wake_i,
                     vbus_i, temp_cold_i, temp_hot_i, undervolt_i,
                     thermal_trip_i, supply_good_i, recovery_strap_n_i,
                     module_reset_line_i, power_en_i};

  psq_pin_sync u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pins    (pins)
  );

  logic                             pe;
  logic                             rl;
  logic                             strap_n;
  logic                             pgood;
  logic                             therm;
  logic                             uvolt;
  logic                             temp_out;
  logic                             vbus;
  logic [psq_pkg::NUM_CONN_WAKE-1:0] conn;
  logic [psq_pkg::NUM_PERIPH_WAKE-1:0] periph;
  logic                             shdn_line;
  logic                             pe_rise;
  logic                             rl_rise;
  logic                             hw_off;
  logic                             shdn_cause;
  logic                             wake;

  assign pe       = pins.synced[psq_pkg::SB_PWR_EN];
  assign rl       = pins.synced[psq_pkg::SB_RST_LINE];
  assign strap_n  = pins.synced[psq_pkg::SB_STRAP_N];
  assign pgood    = pins.synced[psq_pkg::SB_PWR_GOOD];
  assign therm    = pins.synced[psq_pkg::SB_THERM];
  assign uvolt    = pins.synced[psq_pkg::SB_UVOLT];
  assign temp_out = pins.synced[psq_pkg::SB_TEMP_HOT]
                  | pins.synced[psq_pkg::SB_TEMP_COLD];
  assign vbus     = pins.synced[psq_pkg::SB_VBUS];
  assign conn     = pins.synced[psq_pkg::SB_CONN_LO +:
                                psq_pkg::NUM_CONN_WAKE];
  assign periph   = pins.synced[psq_pkg::SB_PERIPH_LO +:
                                psq_pkg::NUM_PERIPH_WAKE];
  assign shdn_line = pins.synced[psq_pkg::SB_SHDN_LINE];

  // only an edge counts; pe_prev resets low, so a request already high at reset still starts us
  assign pe_rise = pe & ~q.pe_prev;
  assign rl_rise = rl & ~q.rl_prev;

  // short dips below the low time are treated as noise
  assign hw_off = (q.st == psq_pkg::ST_ON)
                & (q.low_cnt >= psq_pkg::HW_OFF_CYC);

  // software may ask only while it is running; thermal needs no guard
  assign shdn_cause = (sw_shutdown_i & sw_running_i) | therm | uvolt;

  assign wake = temp_out
              | (vbus & vbus_wake_en_i)
              | (|(conn & conn_wake_en_i))
              | (|periph);

  always_comb begin
    d         = q;
    d.pe_prev = pe;
    d.rl_prev = rl;
    if (pe) begin
      d.low_cnt = '0;
    end else if (q.low_cnt != psq_pkg::HW_OFF_CYC) begin
      d.low_cnt = q.low_cnt + psq_pkg::CNT_W'(1);
    end
    // strap is caught at the release edge of the reset line
    if (rl_rise) begin
      d.recovery = ~strap_n;
    end
    // a carrier pull on the line resets soc and storage alike
    d.soc_rst_n = rl & q.rst_oe_n;
    unique case (q.st)
      psq_pkg::ST_OFF: begin
        if (pe_rise) begin
          d.st      = psq_pkg::ST_PWR_UP;
          d.pmic_en = 1'b1;
        end
      end
      psq_pkg::ST_PWR_UP: begin
        if (therm) begin
          d.st        = psq_pkg::ST_SHUT_WAIT;
          d.shdn_oe_n = 1'b0;
        end else if (!pe) begin
          d.st      = psq_pkg::ST_PWR_DOWN;
          d.pmic_en = 1'b0;
        end else if (pgood) begin
          d.st       = psq_pkg::ST_ON;
          d.rst_oe_n = 1'b1;
        end
      end
      psq_pkg::ST_ON: begin
        if (hw_off) begin
          // request is already low, so supplies may go at once
          d.st        = psq_pkg::ST_PWR_DOWN;
          d.shdn_oe_n = 1'b0;
          d.rst_oe_n  = 1'b0;
          d.pmic_en   = 1'b0;
        end else if (shdn_cause) begin
          d.st        = psq_pkg::ST_SHUT_WAIT;
          d.shdn_oe_n = 1'b0;
        end else if (sleep_req_i) begin
          d.st       = psq_pkg::ST_SLEEP;
          d.asleep_n = 1'b0;
          d.io_hold  = 1'b1;
        end
      end
      psq_pkg::ST_SLEEP: begin
        // pad levels are left untouched here, so they hold
        if (therm) begin
          d.st        = psq_pkg::ST_SHUT_WAIT;
          d.shdn_oe_n = 1'b0;
          d.asleep_n  = 1'b1;
          d.io_hold   = 1'b0;
        end else if (wake) begin
          d.st       = psq_pkg::ST_ON;
          d.asleep_n = 1'b1;
          d.io_hold  = 1'b0;
        end
      end
      psq_pkg::ST_SHUT_WAIT: begin
        // even a self-requested shutdown waits for the carrier to drop
        if (!pe) begin
          d.st       = psq_pkg::ST_PWR_DOWN;
          d.rst_oe_n = 1'b0;
          d.pmic_en  = 1'b0;
        end
      end
      psq_pkg::ST_PWR_DOWN: begin
        if (!pgood) begin
          d.st        = psq_pkg::ST_OFF;
          d.shdn_oe_n = 1'b1;
        end
      end
      default: begin
        d = CORE_RST;
      end
    endcase
    unique case (d.st)
      psq_pkg::ST_OFF:   d.pstate = psq_pkg::PST_OFF;
      psq_pkg::ST_SLEEP: d.pstate = psq_pkg::PST_SLEEP;
      default:           d.pstate = psq_pkg::PST_ON;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  // open-drain lines only ever pull low
  assign module_reset_line_o      = 1'b0;
  assign module_reset_line_oe_n_o = q.rst_oe_n;
  assign shutdown_req_o           = 1'b0;
  assign shutdown_req_oe_n_o      = q.shdn_oe_n;
  assign asleep_indicator_n_o     = q.asleep_n;
  assign supply_enable_o          = q.pmic_en;
  assign soc_reset_n_o            = q.soc_rst_n;
  assign storage_reset_n_o        = q.soc_rst_n;
  assign recovery_mode_o          = q.recovery;
  assign io_hold_o                = q.io_hold;
  assign power_state_o            = q.pstate;

  // checks on the sequencing
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_pe_drop;
    pe ##1 !pe;
  endsequence

  sequence s_sleep_entry;
    (q.st == psq_pkg::ST_ON) ##1 (q.st == psq_pkg::ST_SLEEP);
  endsequence

  property p_on_event;
    (q.st == psq_pkg::ST_OFF) && !pe_rise |=> (q.st == psq_pkg::ST_OFF);
  endproperty
  a_on_event: assert property (p_on_event)
    else $error("left OFF without a power-on rising edge");

  property p_release;
    $rose(module_reset_line_oe_n_o) |->
      $past(q.st == psq_pkg::ST_PWR_UP) && $past(pgood);
  endproperty
  a_release: assert property (p_release)
    else $error("reset line released before power-up completed");

  property p_soc_reset;
    !rl |=> !soc_reset_n_o && !storage_reset_n_o;
  endproperty
  a_soc_reset: assert property (p_soc_reset)
    else $error("soc or storage not held in reset");

  property p_hw_off_time;
    (q.st == psq_pkg::ST_ON) ##1 (q.st == psq_pkg::ST_PWR_DOWN) |->
      $past(q.low_cnt) == psq_pkg::HW_OFF_CYC && !pe;
  endproperty
  a_hw_off_time: assert property (p_hw_off_time)
    else $error("hardware shutdown taken before the low time");

  property p_shdn_req;
    (q.st == psq_pkg::ST_SHUT_WAIT) |-> !shutdown_req_oe_n_o;
  endproperty
  a_shdn_req: assert property (p_shdn_req)
    else $error("shutdown request not driven while waiting");

  property p_wait_drop;
    (q.st == psq_pkg::ST_SHUT_WAIT) && pe |=>
      (q.st == psq_pkg::ST_SHUT_WAIT) && supply_enable_o;
  endproperty
  a_wait_drop: assert property (p_wait_drop)
    else $error("supply shutdown began with power-on request high");

  property p_reset_after_fall;
    s_pe_drop ##0 (q.st == psq_pkg::ST_SHUT_WAIT) |=>
      !module_reset_line_oe_n_o && !supply_enable_o;
  endproperty
  a_reset_after_fall: assert property (p_reset_after_fall)
    else $error("reset line not asserted after request fell");

  property p_sleep_from_on;
    $rose(q.st == psq_pkg::ST_SLEEP) |-> $past(q.st == psq_pkg::ST_ON);
  endproperty
  a_sleep_from_on: assert property (p_sleep_from_on)
    else $error("SLEEP entered from a state other than ON");

  property p_hold;
    s_sleep_entry ##1 (q.st == psq_pkg::ST_SLEEP) |->
      $stable(module_reset_line_oe_n_o) && $stable(shutdown_req_oe_n_o)
      && $stable(supply_enable_o) && io_hold_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("output level changed during sleep");

  property p_no_wake;
    (q.st == psq_pkg::ST_SLEEP) && !wake && !therm |=>
      (q.st == psq_pkg::ST_SLEEP);
  endproperty
  a_no_wake: assert property (p_no_wake)
    else $error("sleep left without a wake event");

  property p_temp_wake;
    (q.st == psq_pkg::ST_SLEEP) && temp_out && !therm |=>
      (q.st == psq_pkg::ST_ON) && asleep_indicator_n_o;
  endproperty
  a_temp_wake: assert property (p_temp_wake)
    else $error("temperature limit did not wake the module");

  property p_asleep;
    (q.st == psq_pkg::ST_SLEEP) == !asleep_indicator_n_o;
  endproperty
  a_asleep: assert property (p_asleep)
    else $error("asleep indicator disagrees with deep sleep");

  property p_recovery;
    rl_rise |=> recovery_mode_o == !$past(strap_n);
  endproperty
  a_recovery: assert property (p_recovery)
    else $error("recovery mode not taken from strap at release");

  property p_shdn_line;
    !shutdown_req_oe_n_o ##2 !shutdown_req_oe_n_o |-> !shdn_line;
  endproperty
  a_shdn_line: assert property (p_shdn_line)
    else $error("shutdown request line not seen low while driven");

endmodule // psq_sequencer

`default_nettype wire
